// File: bench/fieldbus_master_model.sv
// Behavioural fieldbus master: sends one 32-byte command frame per start pulse
// and collects the response bytes. Assumes rxReady and txValid settle before clk rises.
module fieldbus_master_model
(
    input  wire logic              clk,
    input  wire logic              start,
    input  wire logic              slow,
    input  wire logic [31:0][7:0]  cmd,
    input  wire logic              rxReady,
    output logic                   rxValid = 1'b0,
    output logic                   rxFirst = 1'b0,
    output logic [7:0]             rxByte = 8'h00,
    input  wire logic              txValid,
    input  wire logic [7:0]        txByte,
    output logic                   txReady = 1'b0,
    output logic [31:0][7:0]       resp = '0,
    output logic [5:0]             respCount = 6'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx = 32;

    always @(posedge clk)
    begin
        if (start)
        begin
            idx = 0;
            respCount <= 6'h00;
        end
        else if (rxValid && rxReady)
            idx = idx + 1;
        rxValid <= idx < 32;
        rxFirst <= idx == 0;
        // An idle line shows the inverse of its last value, never a stale byte.
        rxByte  <= (idx < 32) ? cmd[idx[4:0]] : ~rxByte;
        txReady <= slow ? ~txReady : 1'b1;
        if (txValid && txReady && !start)
        begin
            resp[respCount[4:0]] <= txByte;
            respCount            <= respCount + 6'h01;
        end
    end
endmodule : fieldbus_master_model

// File: bench/remote_io_frame_map_tb.sv
// Self-checking bench for the cyclic exchange framer.
// Assumes the package, interface and design files are compiled first.
module remote_io_frame_map_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, variantTwo = 1'b0, start = 1'b0, slow = 1'b0;
    logic rxValid, rxFirst, rxReady, frameStrobe, frameError, txValid, txLast, txReady;
    logic [31:0][7:0] cmd = '0, resp;
    logic [7:0][15:0] ioInput;
    logic [7:0][15:0] ioOutput = 128'h7E71_6D62_5C53_4B44_3A35_2937_1826_0715;
    logic [15:0] regAddr, cmdWord, respCmd = 16'h8C41, connStatus = 16'h0F3E;
    logic [31:0] writeData, readData = 32'hD4C3B2A1;
    logic [7:0] rxByte, txByte, watchdogCount, cmdControl;
    logic [7:0] alarmByte = 8'h5A, ctrlStatus = 8'hC6;
    logic [5:0] respCount;
    int failures = 0, num_checks = 0;

    initial forever #4 clk = ~clk;

    remote_io_frame_map uut (.clk(clk), .nrst(nrst), .variantTwo(variantTwo), .rxValid(rxValid),
        .rxFirst(rxFirst), .rxByte(rxByte), .rxReady(rxReady), .ioInput(ioInput),
        .regAddr(regAddr), .cmdWord(cmdWord), .writeData(writeData),
        .watchdogCount(watchdogCount), .cmdControl(cmdControl), .frameStrobe(frameStrobe),
        .frameError(frameError), .ioOutput(ioOutput), .respCmd(respCmd), .readData(readData),
        .alarmByte(alarmByte), .ctrlStatus(ctrlStatus), .connStatus(connStatus),
        .txValid(txValid), .txByte(txByte), .txLast(txLast), .txReady(txReady));

    fieldbus_master_model master (.clk(clk), .start(start), .slow(slow), .cmd(cmd),
        .rxReady(rxReady), .rxValid(rxValid), .rxFirst(rxFirst), .rxByte(rxByte),
        .txValid(txValid), .txByte(txByte), .txReady(txReady), .resp(resp),
        .respCount(respCount));

    task automatic check(input string name, input logic [31:0] expv, input logic [31:0] seen);
        num_checks++;
        if (seen !== expv)
        begin
            $display("mismatch %s expected %h seen %h", name, expv, seen);
            failures++;
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // A good frame must commit and answer; a frame with the other layout's code is dropped.
    task automatic run_frame(input logic v2, input logic sl, input logic [7:0] salt,
                             input logic good);
        int i;
        logic [31:0][7:0] exp;
        logic [15:0] oldAddr;
        logic [5:0] lastAt;
        oldAddr = regAddr;
        @(posedge clk);
        variantTwo <= v2;
        slow <= sl;
        for (i = 0; i < 32; i++)
            cmd[i] <= (i == 0) ? (((v2 ^ !good) != 0) ? 8'h20 : 8'h50) : 8'(i * 13) ^ salt;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (i = 0; i < 100 && frameStrobe !== 1'b1 && frameError !== 1'b1; i++)
            @(negedge clk);
        if (i == 100)
        begin
            failures++;
            report_and_stop();
        end
        check("frameStrobe", 32'(good), 32'(frameStrobe));
        check("frameError", 32'(!good), 32'(frameError));
        check("rxReady held off", 32'(!good), 32'(rxReady));
        if (!good)
            check("regAddr kept", 32'(oldAddr), 32'(regAddr));
        else
        begin
            for (i = 0; i < 8; i++)
                check("ioInput", {cmd[7 + 2 * i], cmd[6 + 2 * i]}, ioInput[i]);
            check("regAddr", {cmd[23], cmd[22]}, regAddr);
            check("cmdWord", {cmd[25], cmd[24]}, cmdWord);
            check("writeData", {cmd[29], cmd[28], cmd[27], cmd[26]}, writeData);
            check("cmdControl", 32'(cmd[2]), 32'(cmdControl));
            if (v2)
                check("watchdogCount", 32'(cmd[1]), 32'(watchdogCount));
            exp = '0;
            exp[0] = v2 ? 8'h20 : 8'h50;
            exp[1] = v2 ? cmd[1] : alarmByte;
            exp[2] = ctrlStatus;
            exp[3] = v2 ? connStatus[7:0] : 8'h00;
            exp[4] = v2 ? connStatus[15:8] : connStatus[7:0];
            exp[5] = v2 ? 8'h00 : connStatus[15:8];
            for (i = 0; i < 8; i++)
                {exp[7 + 2 * i], exp[6 + 2 * i]} = ioOutput[i];
            {exp[23], exp[22], exp[25], exp[24]} = {cmd[23], cmd[22], respCmd};
            {exp[29], exp[28], exp[27], exp[26]} = readData;
            lastAt = 6'h3F;
            for (i = 0; i < 400 && respCount !== 6'h20; i++)
            begin
                // The byte flagged last must be the 32nd one offered.
                if (txValid === 1'b1 && txLast === 1'b1 && lastAt == 6'h3F)
                    lastAt = respCount;
                @(negedge clk);
            end
            if (i == 400)
            begin
                failures++;
                report_and_stop();
            end
            for (i = 0; i < 32; i++)
                check($sformatf("resp byte %0d", i), 32'(exp[i]), 32'(resp[i]));
            check("txLast position", 32'h0000_001F, 32'(lastAt));
            check("rxReady after response", 32'h0000_0001, 32'(rxReady));
        end
        $display("frame done variantTwo=%0b good=%0b", v2, good);
    endtask : run_frame

    initial
    begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        run_frame(1'b0, 1'b0, 8'h3C, 1'b1);
        run_frame(1'b1, 1'b1, 8'hA5, 1'b1);
        run_frame(1'b0, 1'b0, 8'h96, 1'b0);
        run_frame(1'b1, 1'b0, 8'h5B, 1'b0);
        run_frame(1'b1, 1'b0, 8'h11, 1'b1);
        run_frame(1'b0, 1'b1, 8'hE7, 1'b1);
        report_and_stop();
    end
endmodule : remote_io_frame_map_tb

// File: hw/frame_field_if.sv
// Carries a frame byte index to the field locator and its answer back.
// Assumes the package has been compiled first.
interface frame_field_if;
    logic                                variantTwo;
    logic [4:0]                          index;
    remote_io_frame_pkg::field_kind_type kind;
    logic [2:0]                          slot;
    logic [1:0]                          lane;

    modport mapper (input variantTwo, input index, output kind, output slot, output lane);
    modport user   (output variantTwo, output index, input kind, input slot, input lane);
endinterface : frame_field_if

// File: hw/frame_field_locator.sv
// Purely combinational locator: frame byte index to field, slot and byte lane.
// Assumes index counts frame bytes from zero in order of transfer.
module frame_field_locator
(
    frame_field_if.mapper field
);
    logic [5:0] pos;
    logic [5:0] codePos;
    logic [5:0] ctrlPos;
    logic [5:0] connPos;
    logic [5:0] slotPos;
    logic [5:0] raddrPos;
    logic [5:0] cmdPos;
    logic [5:0] dataPos;
    logic [5:0] fieldBase;
    logic [5:0] slotRel;
    logic [5:0] laneRel;
    logic       v2;

    assign v2       = field.variantTwo;
    assign pos      = v2 ? {1'b0, field.index}
                         : 6'({1'b0, field.index} + remote_io_frame_pkg::V1_POS_SHIFT);
    assign codePos  = v2 ? remote_io_frame_pkg::V2_CODE_POS  : remote_io_frame_pkg::V1_CODE_POS;
    assign ctrlPos  = v2 ? remote_io_frame_pkg::V2_CTRL_POS  : remote_io_frame_pkg::V1_CTRL_POS;
    assign connPos  = v2 ? remote_io_frame_pkg::V2_CONN_POS  : remote_io_frame_pkg::V1_CONN_POS;
    assign slotPos  = v2 ? remote_io_frame_pkg::V2_SLOT_POS  : remote_io_frame_pkg::V1_SLOT_POS;
    assign raddrPos = v2 ? remote_io_frame_pkg::V2_RADDR_POS : remote_io_frame_pkg::V1_RADDR_POS;
    assign cmdPos   = v2 ? remote_io_frame_pkg::V2_CMD_POS   : remote_io_frame_pkg::V1_CMD_POS;
    assign dataPos  = v2 ? remote_io_frame_pkg::V2_DATA_POS  : remote_io_frame_pkg::V1_DATA_POS;

    // The field layout for both variants.
    assign field.kind =
        (pos == codePos) ? remote_io_frame_pkg::FK_CODE :
        (v2 && pos == remote_io_frame_pkg::V2_WDOG_POS) ? remote_io_frame_pkg::FK_WDOG :
        (pos == ctrlPos) ? remote_io_frame_pkg::FK_CTRL :
        (!v2 && pos == remote_io_frame_pkg::V1_ALARM_POS) ? remote_io_frame_pkg::FK_ALARM :
        remote_io_frame_pkg::in_field(pos, connPos, remote_io_frame_pkg::CONN_LEN)
            ? remote_io_frame_pkg::FK_CONN :
        remote_io_frame_pkg::in_field(pos, slotPos, remote_io_frame_pkg::SLOT_AREA_LEN)
            ? remote_io_frame_pkg::FK_SLOT :
        remote_io_frame_pkg::in_field(pos, raddrPos, remote_io_frame_pkg::WORD16_LEN)
            ? remote_io_frame_pkg::FK_RADDR :
        remote_io_frame_pkg::in_field(pos, cmdPos, remote_io_frame_pkg::WORD16_LEN)
            ? remote_io_frame_pkg::FK_CMD :
        remote_io_frame_pkg::in_field(pos, dataPos, remote_io_frame_pkg::DATA_LEN)
            ? remote_io_frame_pkg::FK_DATA :
        remote_io_frame_pkg::FK_RSVD;

    assign fieldBase = (field.kind == remote_io_frame_pkg::FK_CONN)  ? connPos  :
                       (field.kind == remote_io_frame_pkg::FK_SLOT)  ? slotPos  :
                       (field.kind == remote_io_frame_pkg::FK_RADDR) ? raddrPos :
                       (field.kind == remote_io_frame_pkg::FK_CMD)   ? cmdPos   :
                       (field.kind == remote_io_frame_pkg::FK_DATA)  ? dataPos  : pos;
    assign slotRel    = 6'(pos - slotPos);
    assign laneRel    = 6'(pos - fieldBase);
    // Slots ascend by driver address, two bytes each, low byte first.
    assign field.slot = slotRel[3:1];
    assign field.lane = (field.kind == remote_io_frame_pkg::FK_SLOT) ? {1'b0, laneRel[0]}
                                                                     : laneRel[1:0];
endmodule : frame_field_locator

// File: hw/remote_io_frame_map.sv
// Cyclic exchange framer: unpacks the 32-byte command frame and packs the response.
// Assumes byte streams synchronous to clk and a response source that holds its
// values steady while a response frame is being sent.
//
// Contract
// - First layout: byte 1 carries code 50h.
// - Second layout: byte 0 carries code 20h.
// - Layout fixed: 16-bit slots, 32-byte frame.
// - Each exchange frame refreshes remote I/O.
// - First layout: slots in bytes 7-22.
// - Second layout: slots in bytes 6-21.
// - Register address two bytes, echoed in response.
// - Command code and trigger in two bytes.
module remote_io_frame_map
(
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                variantTwo,
    input  wire logic                rxValid,
    input  wire logic                rxFirst,
    input  wire logic [7:0]          rxByte,
    output logic                     rxReady,
    output logic [7:0][15:0]         ioInput,
    output logic [15:0]              regAddr,
    output logic [15:0]              cmdWord,
    output logic [31:0]              writeData,
    output logic [7:0]               watchdogCount,
    output logic [7:0]               cmdControl,
    output logic                     frameStrobe,
    output logic                     frameError,
    input  wire logic [7:0][15:0]    ioOutput,
    input  wire logic [15:0]         respCmd,
    input  wire logic [31:0]         readData,
    input  wire logic [7:0]          alarmByte,
    input  wire logic [7:0]          ctrlStatus,
    input  wire logic [15:0]         connStatus,
    output logic                     txValid,
    output logic [7:0]               txByte,
    output logic                     txLast,
    input  wire logic                txReady
);
    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rstPipe_reg;
    logic       rstN;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst) rstPipe_reg <= 2'h0;
        else       rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
    assign rstN = rstPipe_reg[1];

    // ------------------------------------------------------------------
    // Field lookup and datapath decode
    // ------------------------------------------------------------------
    frame_field_if field ();
    frame_field_locator locator (.field(field));

    remote_io_frame_pkg::frame_state_type state_reg;
    remote_io_frame_pkg::frame_state_type state_next;
    logic [4:0]        rxCount_reg;
    logic [4:0]        txCount_reg;
    logic [4:0]        rxIndex;
    logic              rxAccept;
    logic              txAccept;
    logic              frameEnd;
    logic              codeOk_reg;
    logic              codeOkFinal;
    logic [7:0]        expectedCode;
    logic [7:0][15:0]  ioShadow_reg;
    logic [15:0]       regShadow_reg;
    logic [15:0]       cmdShadow_reg;
    logic [31:0]       dataShadow_reg;
    logic [7:0]        wdogShadow_reg;
    logic [7:0]        ctrlShadow_reg;
    logic [7:0]        respByte;
    logic [15:0]       slotOut;

    assign expectedCode     = variantTwo ? remote_io_frame_pkg::V2_EXCHANGE_CODE
                                         : remote_io_frame_pkg::V1_EXCHANGE_CODE;
    // The sender is held off while a response is going out; no buffering.
    assign rxReady          = (state_reg == remote_io_frame_pkg::ST_RECV);
    assign rxAccept         = rxValid && rxReady;
    assign txAccept         = txValid && txReady;
    assign rxIndex          = rxFirst ? 5'h00 : rxCount_reg;
    assign field.variantTwo = variantTwo;
    assign field.index      = (state_reg == remote_io_frame_pkg::ST_RECV) ? rxIndex
                                                                          : txCount_reg;
    assign frameEnd         = rxAccept && (rxIndex == remote_io_frame_pkg::LAST_INDEX);
    assign codeOkFinal      = (field.kind == remote_io_frame_pkg::FK_CODE)
                              ? (rxByte == expectedCode) : codeOk_reg;
    assign slotOut          = ioOutput[field.slot];

    // Response byte for the field at txCount.
    always_comb
    begin
        case (field.kind)
            remote_io_frame_pkg::FK_CODE:  respByte = expectedCode;
            remote_io_frame_pkg::FK_WDOG:  respByte = wdogShadow_reg;
            remote_io_frame_pkg::FK_CTRL:  respByte = ctrlStatus;
            remote_io_frame_pkg::FK_ALARM: respByte = alarmByte;
            remote_io_frame_pkg::FK_CONN:
                respByte = remote_io_frame_pkg::get_byte({16'h0000, connStatus}, field.lane);
            remote_io_frame_pkg::FK_SLOT:
                respByte = remote_io_frame_pkg::get_byte({16'h0000, slotOut}, field.lane);
            remote_io_frame_pkg::FK_RADDR:
                respByte = remote_io_frame_pkg::get_byte({16'h0000, regShadow_reg}, field.lane);
            remote_io_frame_pkg::FK_CMD:
                respByte = remote_io_frame_pkg::get_byte({16'h0000, respCmd}, field.lane);
            remote_io_frame_pkg::FK_DATA:
                respByte = remote_io_frame_pkg::get_byte(readData, field.lane);
            default:                       respByte = 8'h00;
        endcase
    end

    always_comb
    begin
        case (state_reg)
            remote_io_frame_pkg::ST_RECV:
                state_next = (frameEnd && codeOkFinal) ? remote_io_frame_pkg::ST_PREP
                                                       : remote_io_frame_pkg::ST_RECV;
            remote_io_frame_pkg::ST_PREP: state_next = remote_io_frame_pkg::ST_SEND;
            remote_io_frame_pkg::ST_SEND:
                state_next = !txAccept ? remote_io_frame_pkg::ST_SEND :
                             txLast    ? remote_io_frame_pkg::ST_RECV
                                       : remote_io_frame_pkg::ST_PREP;
            default:                      state_next = remote_io_frame_pkg::ST_RECV;
        endcase
    end

    // ------------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state_reg      <= remote_io_frame_pkg::ST_RECV;
            rxCount_reg    <= 5'h00;
            codeOk_reg     <= 1'b0;
            ioShadow_reg   <= '0;
            regShadow_reg  <= 16'h0000;
            cmdShadow_reg  <= 16'h0000;
            dataShadow_reg <= 32'h0000_0000;
            wdogShadow_reg <= 8'h00;
            ctrlShadow_reg <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            if (rxAccept)
            begin
                rxCount_reg <= 5'(rxIndex + 5'h01);
                codeOk_reg  <= codeOkFinal;
                case (field.kind)
                    remote_io_frame_pkg::FK_SLOT: ioShadow_reg[field.slot] <=
                        16'(remote_io_frame_pkg::put_byte({16'h0000, ioShadow_reg[field.slot]},
                                                          field.lane, rxByte));
                    remote_io_frame_pkg::FK_RADDR: regShadow_reg <=
                        16'(remote_io_frame_pkg::put_byte({16'h0000, regShadow_reg},
                                                          field.lane, rxByte));
                    remote_io_frame_pkg::FK_CMD: cmdShadow_reg <=
                        16'(remote_io_frame_pkg::put_byte({16'h0000, cmdShadow_reg},
                                                          field.lane, rxByte));
                    remote_io_frame_pkg::FK_DATA: dataShadow_reg <=
                        remote_io_frame_pkg::put_byte(dataShadow_reg, field.lane, rxByte);
                    remote_io_frame_pkg::FK_WDOG: wdogShadow_reg <= rxByte;
                    remote_io_frame_pkg::FK_CTRL: ctrlShadow_reg <= rxByte;
                    default: ;
                endcase
            end
        end
    end

    // Outputs move together only at the end of a good frame, so the user side
    // never sees a half-written frame.
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            ioInput       <= '0;
            regAddr       <= 16'h0000;
            cmdWord       <= 16'h0000;
            writeData     <= 32'h0000_0000;
            watchdogCount <= 8'h00;
            cmdControl    <= 8'h00;
            frameStrobe   <= 1'b0;
            frameError    <= 1'b0;
        end
        else
        begin
            frameStrobe <= frameEnd && codeOkFinal;
            frameError  <= frameEnd && !codeOkFinal;
            if (frameEnd && codeOkFinal)
            begin
                ioInput       <= ioShadow_reg;
                regAddr       <= regShadow_reg;
                cmdWord       <= cmdShadow_reg;
                writeData     <= dataShadow_reg;
                watchdogCount <= wdogShadow_reg;
                cmdControl    <= ctrlShadow_reg;
            end
        end
    end

    // ------------------------------------------------------------------
    // Response side
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            txCount_reg <= 5'h00;
            txValid     <= 1'b0;
            txByte      <= 8'h00;
            txLast      <= 1'b0;
        end
        else if (state_reg == remote_io_frame_pkg::ST_PREP)
        begin
            txValid <= 1'b1;
            txByte  <= respByte;
            txLast  <= (txCount_reg == remote_io_frame_pkg::LAST_INDEX);
        end
        else if (txAccept)
        begin
            txValid     <= 1'b0;
            txLast      <= 1'b0;
            txCount_reg <= 5'(txCount_reg + 5'h01);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    a_first_code_v1: assert property (!variantTwo && txValid && txCount_reg == 5'h00
        |-> txByte == 8'h50) else $error("first layout response code wrong");
    a_first_code_v2: assert property (variantTwo && txValid && txCount_reg == 5'h00
        |-> txByte == 8'h20) else $error("second layout response code wrong");
    a_frame_length: assert property ((frameStrobe || frameError)
        |-> $past(rxAccept) && $past(rxIndex) == 5'h1F) else $error("frame not 32 bytes");
    a_io_refresh: assert property (!$stable(ioInput) |-> frameStrobe)
        else $error("remote I/O changed outside an exchange");
    a_slot_v1: assert property (!variantTwo && rxAccept && rxIndex == 5'h06
        |-> field.kind == remote_io_frame_pkg::FK_SLOT && field.slot == 3'h0)
        else $error("first layout slot 0 misplaced");
    a_slot_v2: assert property (variantTwo && rxAccept && rxIndex == 5'h15
        |-> field.kind == remote_io_frame_pkg::FK_SLOT && field.slot == 3'h7 && field.lane == 2'h1)
        else $error("second layout slot 7 misplaced");
    a_raddr_place: assert property (rxAccept && rxIndex == (variantTwo ? 5'h16 : 5'h16)
        |-> field.kind == remote_io_frame_pkg::FK_RADDR && field.lane == (variantTwo ? 2'h0 : 2'h0))
        else $error("register address misplaced");
    a_cmd_place: assert property (rxAccept && rxIndex == 5'h18
        |-> field.kind == remote_io_frame_pkg::FK_CMD && field.lane == (variantTwo ? 2'h0 : 2'h0))
        else $error("command field misplaced");
    a_data_place: assert property (rxAccept && rxIndex == 5'h1D
        |-> field.kind == remote_io_frame_pkg::FK_DATA && field.lane == 2'h3)
        else $error("data field misplaced");
    a_wdog_echo: assert property (variantTwo && txValid && txCount_reg == 5'h01
        |-> txByte == wdogShadow_reg) else $error("watchdog echo wrong");
    a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txByte))
        else $error("response byte dropped under stall");

    c_good_v1: cover property (frameStrobe && !variantTwo);
    c_good_v2: cover property (frameStrobe && variantTwo);
    c_bad_code: cover property (frameError);
    c_resp_done: cover property (txAccept && txLast);
endmodule : remote_io_frame_map

// File: hw/remote_io_frame_pkg.sv
// Constants, field layouts and types of the 32-byte cyclic exchange frame.
// Assumes both layouts use 16-bit remote I/O slots and a 32-byte frame.
package remote_io_frame_pkg;

    // ------------------------------------------------------------------
    // Frame geometry
    // ------------------------------------------------------------------
    localparam int          FRAME_BYTES       = 32;
    localparam int          SLOT_COUNT        = 8;
    localparam logic [4:0]  LAST_INDEX        = 5'h1F;
    localparam logic [7:0]  V1_EXCHANGE_CODE  = 8'h50;
    localparam logic [7:0]  V2_EXCHANGE_CODE  = 8'h20;

    // Printed byte positions; the first layout numbers its first byte 1.
    localparam logic [5:0]  V1_POS_SHIFT      = 6'h01;
    localparam logic [5:0]  V1_CODE_POS       = 6'h01;
    localparam logic [5:0]  V1_ALARM_POS      = 6'h02;
    localparam logic [5:0]  V1_CTRL_POS       = 6'h03;
    localparam logic [5:0]  V1_CONN_POS       = 6'h05;
    localparam logic [5:0]  V1_SLOT_POS       = 6'h07;
    localparam logic [5:0]  V1_RADDR_POS      = 6'h17;
    localparam logic [5:0]  V1_CMD_POS        = 6'h19;
    localparam logic [5:0]  V1_DATA_POS       = 6'h1B;
    localparam logic [5:0]  V2_CODE_POS       = 6'h00;
    localparam logic [5:0]  V2_WDOG_POS       = 6'h01;
    localparam logic [5:0]  V2_CTRL_POS       = 6'h02;
    localparam logic [5:0]  V2_CONN_POS       = 6'h03;
    localparam logic [5:0]  V2_SLOT_POS       = 6'h06;
    localparam logic [5:0]  V2_RADDR_POS      = 6'h16;
    localparam logic [5:0]  V2_CMD_POS        = 6'h18;
    localparam logic [5:0]  V2_DATA_POS       = 6'h1A;
    localparam logic [5:0]  CONN_LEN          = 6'h02;
    localparam logic [5:0]  SLOT_AREA_LEN     = 6'h10;
    localparam logic [5:0]  WORD16_LEN        = 6'h02;
    localparam logic [5:0]  DATA_LEN          = 6'h04;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [9:0]
    {
        FK_CODE  = 10'h001,
        FK_WDOG  = 10'h002,
        FK_CTRL  = 10'h004,
        FK_ALARM = 10'h008,
        FK_CONN  = 10'h010,
        FK_SLOT  = 10'h020,
        FK_RADDR = 10'h040,
        FK_CMD   = 10'h080,
        FK_DATA  = 10'h100,
        FK_RSVD  = 10'h200
    } field_kind_type;

    typedef enum logic [2:0]
    {
        ST_RECV = 3'h1,
        ST_PREP = 3'h2,
        ST_SEND = 3'h4
    } frame_state_type;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic in_field(input logic [5:0] pos, input logic [5:0] base,
                                      input logic [5:0] len);
        in_field = (pos >= base) && (pos < 6'(base + len));
    endfunction : in_field

    function automatic logic [31:0] put_byte(input logic [31:0] word, input logic [1:0] lane,
                                             input logic [7:0] value);
        logic [31:0] result;
        result = word;
        result[{lane, 3'h0} +: 8] = value;
        put_byte = result;
    endfunction : put_byte

    function automatic logic [7:0] get_byte(input logic [31:0] word, input logic [1:0] lane);
        get_byte = word[{lane, 3'h0} +: 8];
    endfunction : get_byte

endpackage : remote_io_frame_pkg
